// file: pkg/nvm_ctrl_pkg.sv
// Package: register offsets, control bit positions, modes and timing for the EEPROM access block
package nvm_ctrl_pkg;
  // I/O space offsets (data-space addresses)
  localparam logic [7:0] CTRL_OFFSET     = 8'h3F;
  localparam logic [7:0] DATA_OFFSET     = 8'h40;
  localparam logic [7:0] ADDR_LO_OFFSET  = 8'h41;
  localparam logic [7:0] ADDR_HI_OFFSET  = 8'h42;
  // Control register bit positions
  localparam int READ_BIT  = 0;
  localparam int PROG_BIT  = 1;
  localparam int ARM_BIT   = 2;
  localparam int IRQEN_BIT = 3;
  localparam int OPSEL_LO  = 4;
  localparam int OPSEL_HI  = 5;
  // Reset values
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [9:0] ADDR_RESET  = 10'h000;
  localparam logic [1:0] OPSEL_RESET = 2'h0;
  // Arm window and stall lengths in CPU cycles
  localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] PROG_STALL_CYCLES = 3'h2;
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
  // Write duration in calibrated oscillator cycles
  localparam int WRITE_OSC_CYCLES = 26368;
  localparam int ADDR_WIDTH = 10;
  localparam int MEM_DEPTH  = 512;
  typedef enum logic [1:0] {
    OP_ERASE_WRITE = 2'b00,
    OP_ERASE_ONLY  = 2'b01,
    OP_WRITE_ONLY  = 2'b10,
    OP_RESERVED    = 2'b11
  } op_sel_t;
endpackage

// file: pkg/nvm_array_if.sv
// Interface: write/read port between the control logic and the byte array
interface nvm_array_if;
  logic       wr_start;
  logic [1:0] op;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       busy;
  modport ctrl  (output wr_start, output op, output addr, output wdata, input rdata, input busy);
  modport array (input wr_start, input op, input addr, input wdata, output rdata, output busy);
endinterface

// file: hw/nvm_byte_array.sv
// Byte array with timed erase/write cycles counted on the calibrated oscillator tick
module nvm_byte_array (
  input  wire logic   clk_i,
  input  wire logic   srst_i,
  input  wire logic   osc_tick_i,
  nvm_array_if.array  arr
);
  logic [7:0]  mem [nvm_ctrl_pkg::MEM_DEPTH];
  logic [14:0] osc_count_reg;
  logic        busy_reg;
  logic [9:0]  addr_reg;
  logic [7:0]  wdata_reg;
  logic [1:0]  op_reg;
  wire         done = busy_reg && osc_tick_i &&
                      (osc_count_reg == 15'(nvm_ctrl_pkg::WRITE_OSC_CYCLES - 1));

  assign arr.busy  = busy_reg;
  assign arr.rdata = mem[arr.addr[8:0]];

  // Cells are not reset; an interrupted write would still complete on silicon
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_reg      <= 1'b0;
      osc_count_reg <= '0;
      addr_reg      <= nvm_ctrl_pkg::ADDR_RESET;
      wdata_reg     <= nvm_ctrl_pkg::DATA_RESET;
      op_reg        <= nvm_ctrl_pkg::OPSEL_RESET;
    end else if (arr.wr_start && !busy_reg) begin
      busy_reg      <= 1'b1;
      osc_count_reg <= '0;
      addr_reg      <= arr.addr;
      wdata_reg     <= arr.wdata;
      op_reg        <= arr.op;
    end else if (done) begin
      busy_reg      <= 1'b0;
    end else if (busy_reg && osc_tick_i) begin
      osc_count_reg <= osc_count_reg + 15'h0001;
    end
  end

  // Erase leaves 0xFF; write-only ANDs new bits into the old value
  always_ff @(posedge clk_i) begin
    if (done) begin
      case (op_reg)
        nvm_ctrl_pkg::OP_ERASE_WRITE: mem[addr_reg[8:0]] <= wdata_reg;
        nvm_ctrl_pkg::OP_ERASE_ONLY:  mem[addr_reg[8:0]] <= 8'hFF;
        nvm_ctrl_pkg::OP_WRITE_ONLY:  mem[addr_reg[8:0]] <= mem[addr_reg[8:0]] & wdata_reg;
        default: ;
      endcase
    end
  end
endmodule // nvm_byte_array

// file: hw/nvm_access_ctrl.sv
// Top: control register, address/data registers, arm window, strobes and CPU stall
// What this block does
// - Program strobe within four cycles of arming starts a write of data byte.
// - Program strobe with arm bit clear does nothing.
// - Arm bit clears itself four cycles after software sets it.
// - No write starts while the self-programming flag is set.
// - Hardware clears program strobe when the write time has elapsed.
// - Setting program strobe halts the CPU for two cycles.
// - Read strobe loads the addressed byte into the data register at once.
// - Each read halts the CPU for four cycles.
// - During a write, reads are refused and the address cannot change.
// - Write lasts 26,368 calibrated oscillator cycles.
// - Operation select: 00 erase+write, 01 erase, 10 write, 11 reserved.
// - Operation select writes are ignored while program strobe is set.
// - With ready enable set, ready interrupt is high while program strobe and self-programming flag are clear.
module nvm_access_ctrl (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic [7:0] io_addr_i,
  input  wire logic [7:0] io_wdata_i,
  input  wire logic       self_program_active_i,
  input  wire logic       osc_tick_i,
  output logic      [7:0] io_rdata_o,
  output logic            cpu_halt_o,
  output logic            ready_irq_o
);
  nvm_array_if arr_if ();

  logic       master_write_arm_reg;
  logic [2:0] arm_count_reg;
  logic       program_strobe_reg;
  logic       ready_irq_enable_reg;
  logic [1:0] operation_select_reg;
  logic [9:0] byte_address_reg;
  logic [7:0] byte_data_reg;
  logic [2:0] halt_count_reg;
  logic [7:0] rdata_reg;
  logic       irq_reg;
  logic       wr_pending_reg;

  wire sel_ctrl = io_addr_i == nvm_ctrl_pkg::CTRL_OFFSET;
  wire sel_data = io_addr_i == nvm_ctrl_pkg::DATA_OFFSET;
  wire sel_alo  = io_addr_i == nvm_ctrl_pkg::ADDR_LO_OFFSET;
  wire sel_ahi  = io_addr_i == nvm_ctrl_pkg::ADDR_HI_OFFSET;
  wire ctrl_wr  = io_wr_i && sel_ctrl;
  wire busy     = program_strobe_reg;
  wire arm_set  = ctrl_wr && io_wdata_i[nvm_ctrl_pkg::ARM_BIT];
  wire prog_req = ctrl_wr && io_wdata_i[nvm_ctrl_pkg::PROG_BIT] && !busy;
  // Arm honoured only if set in an earlier access, still inside its window
  wire prog_go  = prog_req && master_write_arm_reg && !self_program_active_i;
  // Program start has priority when both strobes arrive together
  wire read_go  = ctrl_wr && io_wdata_i[nvm_ctrl_pkg::READ_BIT] && !busy && !prog_go;
  wire arm_done = master_write_arm_reg && (arm_count_reg == nvm_ctrl_pkg::ARM_WINDOW_CYCLES - 3'h1);
  wire [7:0] ctrl_view = {2'b00, operation_select_reg, ready_irq_enable_reg,
                          master_write_arm_reg, program_strobe_reg, 1'b0};
  // Read strobe bit always reads back as zero

  // Array latches address, data and mode at the start pulse
  assign arr_if.wr_start = wr_pending_reg;
  assign arr_if.op       = operation_select_reg;
  assign arr_if.addr     = byte_address_reg;
  assign arr_if.wdata    = byte_data_reg;

  nvm_byte_array u_array (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .osc_tick_i (osc_tick_i),
    .arr        (arr_if.array)
  );

  // Arm window
  // Arm write wins over expiry so a rewrite always restarts the count
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      master_write_arm_reg <= 1'b0;
      arm_count_reg        <= 3'h0;
    end else if (arm_set) begin
      master_write_arm_reg <= 1'b1;
      arm_count_reg        <= 3'h0;
    end else if (arm_done || prog_go) begin
      master_write_arm_reg <= 1'b0;
      arm_count_reg        <= 3'h0;
    end else if (master_write_arm_reg) begin
      arm_count_reg        <= arm_count_reg + 3'h1;
    end
  end

  // Program strobe: set on a valid start, cleared when the array finishes
  // Pending flag holds off the clear until the array has seen the start
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      program_strobe_reg <= 1'b0;
      wr_pending_reg     <= 1'b0;
    end else begin
      wr_pending_reg <= prog_go;
      if (prog_go) begin
        program_strobe_reg <= 1'b1;
      end else if (program_strobe_reg && !wr_pending_reg && !arr_if.busy) begin
        program_strobe_reg <= 1'b0;
      end
    end
  end

  // Control fields, address and data
  // Enable bit stays writable during a write; only mode and address lock
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ready_irq_enable_reg <= 1'b0;
      operation_select_reg <= nvm_ctrl_pkg::OPSEL_RESET;
      byte_address_reg     <= nvm_ctrl_pkg::ADDR_RESET;
      byte_data_reg        <= nvm_ctrl_pkg::DATA_RESET;
    end else begin
      if (ctrl_wr) begin
        ready_irq_enable_reg <= io_wdata_i[nvm_ctrl_pkg::IRQEN_BIT];
        if (!busy) begin
          operation_select_reg <= io_wdata_i[nvm_ctrl_pkg::OPSEL_HI:nvm_ctrl_pkg::OPSEL_LO];
        end
      end
      if (io_wr_i && sel_alo && !busy) begin
        byte_address_reg[7:0] <= io_wdata_i;
      end
      if (io_wr_i && sel_ahi && !busy) begin
        byte_address_reg[9:8] <= io_wdata_i[1:0];
      end
      if (read_go) begin
        byte_data_reg <= arr_if.rdata;
      end else if (io_wr_i && sel_data) begin
        byte_data_reg <= io_wdata_i;
      end
    end
  end

  // CPU halt after a program start or a read
  // Count loaded as length minus one; output drops once it reaches zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      halt_count_reg <= 3'h0;
      cpu_halt_o     <= 1'b0;
    end else if (prog_go) begin
      halt_count_reg <= nvm_ctrl_pkg::PROG_STALL_CYCLES - 3'h1;
      cpu_halt_o     <= 1'b1;
    end else if (read_go) begin
      halt_count_reg <= nvm_ctrl_pkg::READ_STALL_CYCLES - 3'h1;
      cpu_halt_o     <= 1'b1;
    end else if (halt_count_reg != 3'h0) begin
      halt_count_reg <= halt_count_reg - 3'h1;
    end else begin
      cpu_halt_o     <= 1'b0;
    end
  end

  // Read data registered; ready interrupt suppressed during self-programming
  // Idle and unmapped cycles return zero so read data can be ORed on the bus
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_reg <= 8'h00;
      irq_reg   <= 1'b0;
    end else begin
      irq_reg <= ready_irq_enable_reg && !program_strobe_reg && !prog_go && !self_program_active_i;
      if (io_rd_i && sel_ctrl) begin
        rdata_reg <= ctrl_view;
      end else if (io_rd_i && sel_data) begin
        rdata_reg <= byte_data_reg;
      end else if (io_rd_i && sel_alo) begin
        rdata_reg <= byte_address_reg[7:0];
      end else if (io_rd_i && sel_ahi) begin
        rdata_reg <= {6'h00, byte_address_reg[9:8]};
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign io_rdata_o  = rdata_reg;
  assign ready_irq_o = irq_reg;
endmodule // nvm_access_ctrl

// file: bench/nvm_access_monitor.sv
// Checker: port-level timing of the EEPROM access block
module nvm_access_monitor (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       io_wr_i,
  input wire logic       io_rd_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic       self_program_active_i,
  input wire logic       osc_tick_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic       cpu_halt_o,
  input wire logic       ready_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [2:0] age_reg;
  wire ctl_wr  = io_wr_i && io_addr_i == nvm_ctrl_pkg::CTRL_OFFSET;
  wire prog_wr = ctl_wr && io_wdata_i[2:0] == 3'h2 && !cpu_halt_o;
  // Cycles since the last arm write, saturating so a stale arm never reopens
  always_ff @(posedge clk_i) begin
    if (srst_i) age_reg <= 3'h7;
    else if (ctl_wr && io_wdata_i[2]) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  end
  property p_rdata_idle; !$past(io_rd_i) |-> io_rdata_o == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_halt_shape;
    $rose(cpu_halt_o) |-> (cpu_halt_o[*2] ##1 !cpu_halt_o) or (cpu_halt_o[*4] ##1 !cpu_halt_o);
  endproperty
  a_halt_shape: assert property (p_halt_shape) else $error("halt length wrong");
  property p_flash_irq; self_program_active_i |=> !ready_irq_o; endproperty
  a_flash_irq: assert property (p_flash_irq) else $error("ready during flash write");
  property p_read_halt;
    ctl_wr && io_wdata_i[1:0] == 2'h1 && ready_irq_o && !cpu_halt_o |=> cpu_halt_o[*4] ##1 !cpu_halt_o;
  endproperty
  a_read_halt: assert property (p_read_halt) else $error("read stall wrong");
  property p_prog_take;
    prog_wr && age_reg < 3'h4 && ready_irq_o && !self_program_active_i
      |=> cpu_halt_o ##1 (cpu_halt_o && !ready_irq_o) ##1 !cpu_halt_o;
  endproperty
  a_prog_take: assert property (p_prog_take) else $error("write not started");
  property p_prog_refuse; prog_wr && age_reg > 3'h3 && ready_irq_o |=> !cpu_halt_o ##1 ready_irq_o; endproperty
  a_prog_refuse: assert property (p_prog_refuse) else $error("write without arm");
  property p_prog_flash; prog_wr && age_reg < 3'h4 && self_program_active_i |=> !cpu_halt_o; endproperty
  a_prog_flash: assert property (p_prog_flash) else $error("write during flash write");
  property p_read_busy;
    ctl_wr && io_wdata_i[0] && !ready_irq_o && !self_program_active_i && !cpu_halt_o |=> !cpu_halt_o;
  endproperty
  a_read_busy: assert property (p_read_busy) else $error("read taken while busy");
  c_prog: cover property (prog_wr && age_reg < 3'h4 && ready_irq_o);
  c_refuse: cover property (prog_wr && age_reg > 3'h3);
  c_read: cover property (ctl_wr && io_wdata_i[1:0] == 2'h1 && ready_irq_o);
endmodule // nvm_access_monitor
bind nvm_access_ctrl nvm_access_monitor i_mon (.clk_i(clk_i), .srst_i(srst_i), .io_wr_i(io_wr_i),
  .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
  .self_program_active_i(self_program_active_i), .osc_tick_i(osc_tick_i), .io_rdata_o(io_rdata_o),
  .cpu_halt_o(cpu_halt_o), .ready_irq_o(ready_irq_o));

// file: bench/nvm_env_model.sv
// Partner model: oscillator ticks and flash self-programming flag
module nvm_env_model (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic flash_req_i,
  output logic      osc_tick_o,
  output logic      self_program_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Tick every cycle keeps the long write short in run time
  always_ff @(posedge clk_i) begin
    osc_tick_o            <= !srst_i;
    self_program_active_o <= flash_req_i;
  end
endmodule // nvm_env_model

// file: bench/eeprom_byte_access_control_tb.sv
// Testbench: register-level write and read sequences for the EEPROM access block
module eeprom_byte_access_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] C = nvm_ctrl_pkg::CTRL_OFFSET, D = nvm_ctrl_pkg::DATA_OFFSET;
  localparam logic [7:0] AL = nvm_ctrl_pkg::ADDR_LO_OFFSET, AH = nvm_ctrl_pkg::ADDR_HI_OFFSET;
  localparam int W = nvm_ctrl_pkg::WRITE_OSC_CYCLES;
  logic clk_i = 1'b0, srst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0, flash_req = 1'b0;
  logic [7:0] io_addr_i = 8'h00, io_wdata_i = 8'h00, io_rdata_o, v;
  logic osc_tick, spm, cpu_halt_o, ready_irq_o;
  logic [7:0] wd [4] = '{8'hA5, 8'h3C, 8'h0F, 8'h33};
  logic [7:0] ex [4] = '{8'hA5, 8'hFF, 8'h0F, 8'h0F};
  int failures = 0, total_checks = 0, cyc = 0, t0;
  always #5 clk_i = ~clk_i;
  nvm_env_model i_env (.clk_i(clk_i), .srst_i(srst_i), .flash_req_i(flash_req), .osc_tick_o(osc_tick),
    .self_program_active_o(spm));
  nvm_access_ctrl i_dut (.clk_i(clk_i), .srst_i(srst_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .self_program_active_i(spm), .osc_tick_i(osc_tick),
    .io_rdata_o(io_rdata_o), .cpu_halt_o(cpu_halt_o), .ready_irq_o(ready_irq_o));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_wr_i <= 1'b1;
    io_addr_i <= a;
    io_wdata_i <= d;
    @(posedge clk_i);
    io_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    io_rd_i <= 1'b1;
    io_addr_i <= a;
    @(posedge clk_i);
    io_rd_i <= 1'b0;
    #1 v = io_rdata_o;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 115000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(C); chk("ctrl reset", 8'h00, v);
    rd(AL); chk("addr reset", 8'h00, v);
    rd(D); chk("data reset", 8'h00, v);
    wr(C, 8'h08);
    @(posedge clk_i);
    #1 chk("ready irq", 8'h01, {7'h0, ready_irq_o});
    wr(AH, 8'h01);
    wr(AL, 8'h05);
    $display("test reset and enable done");
    for (int m = 0; m < 4; m++) begin
      wr(D, wd[m]);
      wr(C, {2'h0, m[1:0], 4'hC});
      wr(C, {2'h0, m[1:0], 4'hA});
      t0 = cyc;
      wr(AL, 8'h07);
      wr(C, 8'h09);
      rd(C); chk("strobe set", {2'h0, m[1:0], 4'hA}, v);
      do begin
        @(posedge clk_i);
        #1;
      end while (ready_irq_o !== 1'b1 && cyc - t0 < W + 1000);
      chk("write time", 8'h01, {7'h0, (cyc - t0) inside {[W:W + 12]}});
      rd(C); chk("strobe clear", {2'h0, m[1:0], 4'h8}, v);
      rd(AL); chk("addr held", 8'h05, v);
      wr(C, {2'h0, m[1:0], 4'h9});
      rd(D); chk("byte", ex[m], v);
      $display("test mode %0d done", m);
    end
    wr(C, 8'h0C);
    repeat (2) @(posedge clk_i);
    wr(C, 8'h0C);
    rd(C); chk("arm restart", 8'h0C, v);
    wr(C, 8'h0C);
    repeat (4) @(posedge clk_i);
    wr(C, 8'h0A);
    rd(C); chk("arm expired", 8'h08, v);
    wr(C, 8'h0A);
    rd(C); chk("no arm", 8'h08, v);
    $display("test refusals done");
    flash_req <= 1'b1;
    wr(C, 8'h0C);
    wr(C, 8'h0A);
    rd(C); chk("flash block", 8'h00, v & 8'h02);
    chk("flash irq", 8'h00, {7'h0, ready_irq_o});
    flash_req <= 1'b0;
    $display("test flash interlock done");
    tally_and_finish();
  end
endmodule // eeprom_byte_access_control_tb
